/* File: src/dual_slope_phase_sequencer.v */
// Phase sequencer and reading counter of a dual-slope integrating converter
//
// Summary of operation
// - Phases run auto-zero, signal integrate, de-integrate, zero-integrator, repeat.
// - Auto-zero shorts inputs to common, charges reference, closes offset loop.
// - Signal integrate opens offset loop, removes short, connects input pins.
// - Signal integrate lasts a fixed time independent of the input.
// - Comparator sampled at end of signal integrate latches the input sign.
// - De-integrate ties low input to common, high input across reference.
// - Reference orientation chosen from latched sign to drive integrator to zero.
// - De-integrate time counted until zero crossing gives the reading.
// - Zero-integrator shorts low to common, recharges reference, loop to high input.
// - Zero-integrator lasts 11 to 140 counts, 740 after heavy overrange.
// - Zero input gives a magnitude reading of exactly zero.
// - Polarity reports true sign even when magnitude is zero.
// - First conversion after overrange is already valid.
// - Conversion counters advance at a quarter of the oscillator rate.
// - Signal integrate 1000 counts, de-integrate 0 to 2000 counts.
// - Auto-zero absorbs leftover counts so each cycle totals 4000 counts.
// - Over 2060 counts overrange: zero-integrator 740, auto-zero 260 counts; the code applies this to every overrange.
`include "sequencer_consts.vh"
module dual_slope_phase_sequencer (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Comparator from the analog front end (asynchronous)
    input wire comparator_out,
    // Switch controls to the analog front end
    output reg input_short_to_common,
    output reg input_pins_connect,
    output reg reference_charge,
    output reg offset_loop_close,
    output reg input_low_to_common,
    output reg reference_connect,
    output reg reference_invert,
    output reg zero_loop_close,
    // Phase indication
    output reg [1:0] phase,
    output reg reference_deintegrate_phase,
    output reg integrator_zeroing_phase,
    // Result for display
    output reg [3:0] reading_ones,
    output reg [3:0] reading_tens,
    output reg [3:0] reading_hundreds,
    output reg reading_thousands,
    output reg reading_negative,
    output reg reading_overrange,
    output reg reading_valid
);
    // ********************************************************
    // Input synchroniser and count enable
    // ********************************************************
    // Only comp_sync is read; comp_meta may still be settling
    reg comp_meta;
    reg comp_sync;
    wire count_en;

    // Comparator is analog and asynchronous; two flops before use
    // The two clocks of delay are made up for in the reading counter
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comparator_out;
            comp_sync <= comp_meta;
        end
    end

    // Divide-by-four tick shared by every counter of the block
    clock_divider u_div (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .count_en(count_en)
    );

    // ********************************************************
    // Phase and cycle counting
    // ********************************************************
    // cycle_count spans the whole measurement cycle; only auto-zero reads it
    reg [11:0] cycle_count;
    reg [11:0] phase_count;
    reg sign_neg;
    reg heavy_over;
    reg prev_comp;
    reg [1:0] next_phase;
    reg phase_done;
    wire deint_end;

    // Zero crossing: comparator changes from its integrate-end value
    // A level compare, not an edge, so a comparator that is already across ends the phase
    wire crossing = (phase == `PH_DEINT) && (comp_sync != prev_comp);

    // De-integrate ends on the crossing or at the full-scale limit
    // The display takes the count before the step of this same tick
    assign deint_end = count_en && (phase == `PH_DEINT) &&
        (crossing || phase_count == `DEINT_MAX_COUNTS - 12'h001);

    // Phase end decisions; signal integrate count is fixed, de-integrate and zeroing can end on the comparator
    // Combinational so the state register and the reading counter clear act on one decision
    always @* begin
        next_phase = phase;
        phase_done = 1'b0;
        case (phase)
            `PH_AUTO_ZERO: begin
                // Auto-zero takes the rest of the 4000-count cycle
                if (cycle_count == `CYCLE_COUNTS - 12'h001) begin
                    phase_done = 1'b1;
                    next_phase = `PH_SIGNAL_INT;
                end
            end
            `PH_SIGNAL_INT: begin
                // Fixed 1000 counts whatever the input
                if (phase_count == `SIGNAL_INT_COUNTS - 12'h001) begin
                    phase_done = 1'b1;
                    next_phase = `PH_DEINT;
                end
            end
            `PH_DEINT: begin
                // Same end condition as deint_end, which drives the display latch
                if (crossing || phase_count == `DEINT_MAX_COUNTS - 12'h001) begin
                    phase_done = 1'b1;
                    next_phase = `PH_ZERO_INT;
                end
            end
            default: begin
                // Heavy overrange stretches zeroing; otherwise stop at 140 counts or once zeroed
                // Once zeroed the comparator is back at the level it showed at integrate end
                if (heavy_over) begin
                    if (phase_count == `ZI_HEAVY_COUNTS - 12'h001) begin
                        phase_done = 1'b1;
                        next_phase = `PH_AUTO_ZERO;
                    end
                end else if (phase_count == `ZI_MAX_COUNTS - 12'h001 ||
                        (phase_count >= `ZI_MIN_COUNTS - 12'h001 && comp_sync == prev_comp)) begin
                    phase_done = 1'b1;
                    next_phase = `PH_AUTO_ZERO;
                end
            end
        endcase
    end

    // Sequencer state; heavy overrange shortens auto-zero to 260 counts
    // Everything here moves on a count tick only, never on the raw core clock
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= `PH_AUTO_ZERO;
            cycle_count <= 12'h000;
            phase_count <= 12'h000;
            sign_neg <= 1'b0;
            heavy_over <= 1'b0;
            prev_comp <= 1'b0;
        end else if (count_en) begin
            // Phase and cycle counts; the end of auto-zero restarts the cycle
            if (phase_done) begin
                phase <= next_phase;
                phase_count <= 12'h000;
                if (phase == `PH_AUTO_ZERO) begin
                    cycle_count <= 12'h000;
                end else begin
                    cycle_count <= cycle_count + 12'h001;
                end
            end else begin
                phase_count <= phase_count + 12'h001;
                cycle_count <= cycle_count + 12'h001;
            end

            // Heavy overrange after zero-integrator: force 260-count auto-zero
            if (phase == `PH_ZERO_INT && phase_done && heavy_over) begin
                cycle_count <= `CYCLE_COUNTS - `AZ_HEAVY_COUNTS;
            end

            // Input sign, and the comparator level that a crossing must leave
            if (phase == `PH_SIGNAL_INT && phase_done) begin
                sign_neg <= comp_sync;
                prev_comp <= comp_sync;
            end

            // The count stops at 2000, so a conversion past 2060 counts cannot be told
            // apart from a lighter overrange; every overrange is taken as heavy, which
            // costs a longer zeroing phase and never a wrong reading
            if (phase == `PH_DEINT && phase_done) begin
                heavy_over <= !crossing;
            end

            // The stretch is served once; the next conversion runs at normal timing
            if (phase == `PH_ZERO_INT && phase_done) begin
                heavy_over <= 1'b0; // Next conversion starts clean
            end
        end
    end

    // ********************************************************
    // Reading counter
    // ********************************************************
    // Digits straight from the decades, copied to the display at end of de-integrate
    wire [3:0] d_ones;
    wire [3:0] d_tens;
    wire [3:0] d_hund;
    wire c_ones;
    wire c_tens;
    wire c_hund;
    reg d_thou;
    wire cnt_clear = count_en && phase == `PH_SIGNAL_INT && phase_done;
    // The first de-integrate tick only covers the switch register, the integrator's first
    // step and the synchroniser; counting it would show a zero input as one count
    wire first_deint_tick = (phase_count == 12'h000);
    // Count only while de-integrating and before the crossing
    wire cnt_step = count_en && phase == `PH_DEINT && !crossing && !first_deint_tick;

    // Three decades; each carry steps the next one on the same tick
    decade_digit u_ones (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(cnt_clear),
        .step(cnt_step),
        .digit(d_ones),
        .carry(c_ones)
    );
    decade_digit u_tens (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(cnt_clear),
        .step(c_ones),
        .digit(d_tens),
        .carry(c_tens)
    );
    decade_digit u_hund (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(cnt_clear),
        .step(c_tens),
        .digit(d_hund),
        .carry(c_hund)
    );

    // Half digit; a zero input crosses at once and leaves all digits zero
    // Set and never cleared by a carry: 1999 is the top of the scale
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            d_thou <= 1'b0;
        end else if (cnt_clear) begin
            d_thou <= 1'b0;
        end else if (c_hund) begin
            d_thou <= 1'b1;
        end
    end

    // Display latch at end of de-integrate; held through other phases
    // Valid stays high once set; an overrange reports through its own flag
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reading_ones <= 4'h0;
            reading_tens <= 4'h0;
            reading_hundreds <= 4'h0;
            reading_thousands <= 1'b0;
            reading_negative <= 1'b0;
            reading_overrange <= 1'b0;
            reading_valid <= 1'b0;
        end else if (deint_end) begin
            reading_ones <= d_ones;
            reading_tens <= d_tens;
            reading_hundreds <= d_hund;
            reading_thousands <= d_thou;
            reading_negative <= sign_neg; // Sign kept even at zero
            reading_overrange <= !crossing;
            reading_valid <= 1'b1; // Every conversion is valid
        end
    end

    // ********************************************************
    // Analog switch decode
    // ********************************************************
    // Registered so the switches never glitch between phases
    // Reset leaves the front end in auto-zero, its safe resting state
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            input_short_to_common <= 1'b1;
            input_pins_connect <= 1'b0;
            reference_charge <= 1'b1;
            offset_loop_close <= 1'b1;
            input_low_to_common <= 1'b0;
            reference_connect <= 1'b0;
            reference_invert <= 1'b0;
            zero_loop_close <= 1'b0;
            reference_deintegrate_phase <= 1'b0;
            integrator_zeroing_phase <= 1'b0;
        end else begin
            input_short_to_common <= (phase == `PH_AUTO_ZERO);
            offset_loop_close <= (phase == `PH_AUTO_ZERO);
            input_pins_connect <= (phase == `PH_SIGNAL_INT);
            reference_charge <= (phase == `PH_AUTO_ZERO) || (phase == `PH_ZERO_INT);
            input_low_to_common <= (phase == `PH_DEINT) || (phase == `PH_ZERO_INT);
            reference_connect <= (phase == `PH_DEINT);
            reference_invert <= (phase == `PH_DEINT) && !sign_neg;
            zero_loop_close <= (phase == `PH_ZERO_INT);
            // Phase flags share the switch timing so the display sees them in step
            reference_deintegrate_phase <= (phase == `PH_DEINT);
            integrator_zeroing_phase <= (phase == `PH_ZERO_INT);
        end
    end
endmodule

/* File: src/sequencer_consts.vh */
// Constants for the dual-slope phase sequencer
`ifndef SEQUENCER_CONSTS_VH
`define SEQUENCER_CONSTS_VH
// Phase codes
`define PH_AUTO_ZERO 2'h0
`define PH_SIGNAL_INT 2'h1
`define PH_DEINT 2'h2
`define PH_ZERO_INT 2'h3
// Oscillator divide ratio
`define OSC_DIVIDE 3'h4
// Phase lengths in counts
`define CYCLE_COUNTS 12'hfa0
`define SIGNAL_INT_COUNTS 12'h3e8
`define DEINT_MAX_COUNTS 12'h7d0
`define HEAVY_OVER_COUNTS 12'h80c
`define ZI_MIN_COUNTS 12'h00b
`define ZI_MAX_COUNTS 12'h08c
`define ZI_HEAVY_COUNTS 12'h2e4
`define AZ_HEAVY_COUNTS 12'h104
`endif

/* File: src/clock_divider.v */
// Divide-by-four enable generator for the conversion counters
`include "sequencer_consts.vh"
module clock_divider (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // One-cycle count enable
    output reg count_en
);
    reg [2:0] div;

    // Pulse once every four core clocks
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div <= 3'h0;
            count_en <= 1'b0;
        end else begin
            if (div == `OSC_DIVIDE - 3'h1) begin
                div <= 3'h0;
                count_en <= 1'b1;
            end else begin
                div <= div + 3'h1;
                count_en <= 1'b0;
            end
        end
    end
endmodule

/* File: src/decade_digit.v */
// One BCD decade of the reading counter with ripple carry
module decade_digit (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Control
    input wire clear,
    input wire step,
    // Digit and carry
    output reg [3:0] digit,
    output wire carry
);
    // Carry when this digit wraps from nine
    assign carry = step && (digit == 4'h9);

    // Count 0..9
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            digit <= 4'h0;
        end else if (clear) begin
            digit <= 4'h0;
        end else if (step) begin
            digit <= (digit == 4'h9) ? 4'h0 : digit + 4'h1;
        end
    end
endmodule

/* File: bench/analog_front_model.sv */
// Behavioural integrator and comparator facing the phase sequencer
module analog_front_model (
    // Clock and switch controls from the sequencer
    input logic core_clk,
    input logic input_pins_connect, offset_loop_close, reference_connect, reference_invert, zero_loop_close,
    // Differential input in thousandths of a count
    input int vin,
    // High while the integrator sits above zero
    output logic comparator_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // One reference clock undoes a quarter count, so four clocks make one count
    localparam longint ref_step = 1000000;
    longint acc = 0;
    // Integrator charge; a wrong reference orientation would run away and never cross
    always @(posedge core_clk) begin
        if (offset_loop_close) begin
            acc <= 0;
        end else if (input_pins_connect) begin
            acc <= acc - vin;
        end else if (reference_connect) begin
            acc <= reference_invert ? acc + ref_step : acc - ref_step;
        end else if (zero_loop_close) begin
            acc <= acc / 2;
        end
    end
    assign comparator_out = (acc > 0);
endmodule

/* File: bench/seq_sva.sv */
// Port-level checks for the dual-slope phase sequencer
module seq_sva (
    // Clock and reset
    input logic core_clk, reset_n,
    // Switch controls
    input logic input_short_to_common, input_pins_connect, reference_charge, offset_loop_close,
    input logic input_low_to_common, reference_connect, reference_invert, zero_loop_close,
    // Phase and result
    input logic [1:0] phase,
    input logic reference_deintegrate_phase, integrator_zeroing_phase,
    input logic [3:0] reading_ones, reading_tens, reading_hundreds,
    input logic reading_thousands, reading_negative, reading_overrange
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] prev_phase;
    logic [14:0] run;
    logic moved;
    assign moved = (phase != prev_phase);
    // Clocks the previous phase lasted, read on the sample where phase moves
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_phase <= 2'h0;
            run <= 15'h0000;
        end else begin
            prev_phase <= phase;
            run <= moved ? 15'h0001 : run + 15'h0001;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_de_end; moved && prev_phase == 2'h2; endsequence
    sequence s_zi_end; moved && prev_phase == 2'h3; endsequence
    property p_order; moved |-> phase == prev_phase + 2'h1; endproperty
    a_order: assert property (p_order) else $error("phase order broken");
    property p_az; prev_phase == 2'h0 |-> input_short_to_common && offset_loop_close && reference_charge
        && !input_pins_connect; endproperty
    a_az: assert property (p_az) else $error("auto-zero switches wrong");
    property p_int; prev_phase == 2'h1 |-> input_pins_connect && !input_short_to_common && !offset_loop_close
        && !reference_charge; endproperty
    a_int: assert property (p_int) else $error("integrate switches wrong");
    property p_de_zi; prev_phase[1] |-> input_low_to_common && !input_pins_connect
        && reference_connect != prev_phase[0] && zero_loop_close == prev_phase[0]; endproperty
    a_de_zi: assert property (p_de_zi) else $error("late phase switches wrong");
    property p_flags; reference_deintegrate_phase == (prev_phase == 2'h2)
        && integrator_zeroing_phase == (prev_phase == 2'h3); endproperty
    a_flags: assert property (p_flags) else $error("phase flags wrong");
    property p_int_len; moved && prev_phase == 2'h1 |-> run == 15'h0fa0; endproperty
    a_int_len: assert property (p_int_len) else $error("integrate length wrong");
    property p_de_max; s_de_end |-> run <= 15'h1f40 && run[1:0] == 2'h0; endproperty
    a_de_max: assert property (p_de_max) else $error("deintegrate length wrong");
    property p_zi_len; s_zi_end |-> reading_overrange ? run == 15'h0b90 : run >= 15'h002c && run <= 15'h0230;
    endproperty
    a_zi_len: assert property (p_zi_len) else $error("zeroing length wrong");
    property p_sign; s_de_end |-> reading_negative == !$past(reference_invert); endproperty
    a_sign: assert property (p_sign) else $error("sign and orientation disagree");
    property p_hold; $changed({reading_thousands, reading_hundreds, reading_tens, reading_ones}) |-> s_de_end;
    endproperty
    a_hold: assert property (p_hold) else $error("reading moved outside deintegrate end");
endmodule
bind dual_slope_phase_sequencer seq_sva seq_sva_i (.core_clk, .reset_n, .input_short_to_common,
    .input_pins_connect, .reference_charge, .offset_loop_close, .input_low_to_common, .reference_connect,
    .reference_invert, .zero_loop_close, .phase, .reference_deintegrate_phase, .integrator_zeroing_phase,
    .reading_ones, .reading_tens, .reading_hundreds,
    .reading_thousands, .reading_negative, .reading_overrange);

/* File: bench/tb_top.sv */
// Self-checking bench for the dual-slope phase sequencer
`define CHECK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected %s expected %0d seen %0d", what, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, reset_n, comparator_out, input_short_to_common, input_pins_connect, reference_charge;
    logic offset_loop_close, input_low_to_common, reference_connect, reference_invert, zero_loop_close;
    logic reference_deintegrate_phase, integrator_zeroing_phase, reading_thousands, reading_negative;
    logic reading_overrange, reading_valid;
    logic [1:0] phase;
    logic [1:0] last = 2'h0;
    logic [3:0] reading_ones, reading_tens, reading_hundreds;
    int vin = 0;
    int bad_count = 0;
    int cmp_count = 0;
    int run = 0;
    int dur [4];
    integer rd, cyc;
    dual_slope_phase_sequencer dual_slope_phase_sequencer_i (.core_clk, .reset_n, .comparator_out,
        .input_short_to_common, .input_pins_connect, .reference_charge, .offset_loop_close, .input_low_to_common,
        .reference_connect, .reference_invert, .zero_loop_close, .phase, .reference_deintegrate_phase,
        .integrator_zeroing_phase, .reading_ones, .reading_tens, .reading_hundreds, .reading_thousands,
        .reading_negative, .reading_overrange, .reading_valid);
    analog_front_model analog_front_model_i (.core_clk, .input_pins_connect, .offset_loop_close,
        .reference_connect, .reference_invert, .zero_loop_close, .vin, .comparator_out);
    // 250 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Clocks spent in each phase, recorded one edge after the phase ends
    always @(posedge core_clk) begin
        if (phase !== last) begin
            dur[last] = run;
            last = phase;
            run = 0;
        end
        run++;
    end
    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for a phase; a hang counts as a mismatch and ends the run
    task wait_phase(input logic [1:0] p);
        for (int n = 0; phase !== p; n++) begin
            if (n == 20000) begin
                `CHECK("phase wait", p, phase)
                give_verdict;
            end else begin
                @(posedge core_clk);
                #1;
            end
        end
    endtask
    // One conversion on a held input; cyc is the previous cycle, read once its auto-zero is logged
    task convert(input int v);
        vin = v;
        wait_phase(2'h1);
        wait_phase(2'h2);
        cyc = dur[0] + dur[1] + dur[2] + dur[3];
        wait_phase(2'h3);
        rd = reading_thousands * 1000 + reading_hundreds * 100 + reading_tens * 10 + reading_ones;
    endtask
    task t_zero;
        convert(0);
        `CHECK("magnitude", 0, rd)
        `CHECK("negative", 1'b0, reading_negative)
        `CHECK("valid", 1'b1, reading_valid)
        $display("test zero done");
    endtask
    // Below one count but negative: zero magnitude, sign kept
    task t_neg_zero;
        convert(-300);
        `CHECK("magnitude", 0, rd)
        `CHECK("negative", 1'b1, reading_negative)
        $display("test negative zero done");
    endtask
    task t_mid;
        convert(500100);
        `CHECK("magnitude window", 1'b1, rd >= 500 && rd <= 501)
        `CHECK("negative", 1'b0, reading_negative)
        `CHECK("integrate clocks", 4000, dur[1])
        $display("test mid scale done");
    endtask
    task t_over;
        convert(2100000);
        `CHECK("cycle clocks", 16000, cyc)
        `CHECK("overrange", 1'b1, reading_overrange)
        $display("test overrange done");
    endtask
    // Right after overrange: stretched zeroing, short auto-zero, then a good reading
    task t_recover;
        convert(-1200100);
        `CHECK("cycle clocks", 16000, cyc)
        `CHECK("zeroing clocks", 2960, dur[3])
        `CHECK("auto-zero clocks", 1040, dur[0])
        `CHECK("magnitude window", 1'b1, rd >= 1200 && rd <= 1201)
        `CHECK("overrange", 1'b0, reading_overrange)
        `CHECK("negative", 1'b1, reading_negative)
        $display("test recovery done");
    endtask
    initial begin
        reset_n = 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        t_zero;
        t_neg_zero;
        t_mid;
        t_over;
        t_recover;
        give_verdict;
    end
endmodule
